// ==== rtl/spp_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the slave port.
`ifndef SPP_DEFINES_SVH
`define SPP_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SPP_ADDR_DATA_PORT 8'h08
`define SPP_ADDR_STROBE_PORT 8'h09
`define SPP_ADDR_IRQ_FLAGS 8'h0C
`define SPP_ADDR_DATA_DIR 8'h88
`define SPP_ADDR_STATUS 8'h89
`define SPP_ADDR_IRQ_ENABLES 8'h8C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SPP_BIT_INPUT_FULL 7
`define SPP_BIT_OUTPUT_FULL 6
`define SPP_BIT_OVERFLOW 5
`define SPP_BIT_ENABLE 4
`define SPP_BIT_IRQ 7
`define SPP_PIN_READ 0
`define SPP_PIN_WRITE 1
`define SPP_PIN_SELECT 2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SPP_RST_STATUS 8'h07
`define SPP_RST_DATA_DIR 8'hFF
`define SPP_RST_LATCH 8'h00

// ----------------------------------------------------------------------
// Timing: one instruction cycle is four clock phases
// ----------------------------------------------------------------------
`define SPP_CLK_NS 50
`define SPP_TCY_NS 200
`define SPP_PHASES (`SPP_TCY_NS / `SPP_CLK_NS)
`define SPP_PHASE_Q1 2'h0
`define SPP_PHASE_Q2 2'h1
`define SPP_PHASE_Q4 2'h3

`endif

// ==== rtl/spp_pkg.sv ====
// Types shared by the slave port modules.
package spp_pkg;

  // Progress of a finished strobe towards its flag update.
  typedef enum logic [1:0] {
    EVT_IDLE = 2'b00,
    EVT_WAIT_Q2 = 2'b01,
    EVT_WAIT_Q4 = 2'b10
  } spp_evt_type;

  // Synchronised strobe levels and their edges.
  typedef struct packed {
    logic rd_act;
    logic wr_act;
    logic rd_start;
    logic rd_end;
    logic wr_end;
    logic [7:0] data;
  } spp_strobe_type;

  // State of the strobe synchroniser.
  typedef struct packed {
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [7:0] data_s1;
    logic [7:0] data_s2;
    spp_strobe_type ev;
  } spp_sync_state_type;

  // State of the port core.
  typedef struct packed {
    logic [1:0] phase;
    logic [7:0] out_latch;
    logic [7:0] in_latch;
    logic [7:0] data_dir;
    logic [2:0] e_latch;
    logic [2:0] e_dir;
    logic input_full;
    logic output_full;
    logic overflow;
    logic enable;
    logic irq_flag;
    logic irq_enable;
    logic [7:0] snap_data;
    logic [2:0] snap_e;
    logic pend_d_valid;
    logic [7:0] pend_d;
    logic pend_e_valid;
    logic [2:0] pend_e;
    spp_evt_type wr_evt;
    spp_evt_type rd_evt;
    logic [7:0] rd_data;
    logic [7:0] data_out;
    logic [7:0] data_oe_b;
    logic [2:0] e_out;
    logic [2:0] e_oe_b;
    logic irq;
  } spp_state_type;

endpackage

// ==== rtl/spp_strobe_sync.sv ====
// Synchroniser and edge detector for the external strobes and data bus.
`timescale 1ns/100ps
`default_nettype none
`include "spp_defines.svh"

module spp_strobe_sync (
  input wire logic clk, // System clock.
  input wire logic rst_b, // Synchronous reset, active low.
  input wire logic enable, // Slave port mode.
  input wire logic [2:0] pin_in, // Strobe pin levels.
  input wire logic [7:0] data_in, // Data bus levels.
  output spp_pkg::spp_strobe_type ev // Registered strobe levels and edges.
);

  spp_pkg::spp_sync_state_type st;
  spp_pkg::spp_sync_state_type next_st;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------

  // Two stages ahead of any decode; only the second stage is decoded.
  always_comb begin
    next_st = st;
    next_st.pin_s1 = pin_in;
    next_st.pin_s2 = st.pin_s1;
    next_st.data_s1 = data_in;
    next_st.data_s2 = st.data_s1;
    next_st.ev.rd_act = enable & ~st.pin_s2[`SPP_PIN_SELECT] & ~st.pin_s2[`SPP_PIN_READ];
    next_st.ev.wr_act = enable & ~st.pin_s2[`SPP_PIN_SELECT] & ~st.pin_s2[`SPP_PIN_WRITE];
    next_st.ev.rd_start = next_st.ev.rd_act & ~st.ev.rd_act;
    next_st.ev.rd_end = ~next_st.ev.rd_act & st.ev.rd_act;
    next_st.ev.wr_end = ~next_st.ev.wr_act & st.ev.wr_act;
    next_st.ev.data = st.data_s2;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Clears all stages on reset.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ev = st.ev;

endmodule
`default_nettype wire

// ==== rtl/spp_core.sv ====
// Parallel slave port with its data and strobe pin ports and registers.
`timescale 1ns/100ps
`default_nettype none
`include "spp_defines.svh"

module spp_core (
  input wire logic clk, // System clock, 20 MHz.
  input wire logic rst_b, // Synchronous reset, active low.
  input wire logic [7:0] addr, // Register address.
  input wire logic [7:0] wr_data, // Register write data.
  input wire logic wr_en, // Register write strobe.
  input wire logic rd_en, // Register read strobe.
  output logic [7:0] rd_data, // Register read data, one cycle later.
  input wire logic [7:0] data_in, // Data port pin levels.
  output logic [7:0] data_out, // Data port drive value.
  output logic [7:0] data_oe_b, // Data port enable, low drives.
  input wire logic [2:0] strobe_in, // Strobe pin levels.
  output logic [2:0] strobe_out, // Strobe pin drive value.
  output logic [2:0] strobe_oe_b, // Strobe pin enable, low drives.
  output logic irq // Interrupt request, active high.
);

  spp_pkg::spp_state_type st;
  spp_pkg::spp_state_type next_st;
  spp_pkg::spp_strobe_type ev;
  logic wr_fire;
  logic rd_fire;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------

  // Steps a finished strobe through the next second and fourth phases.
  function automatic spp_pkg::spp_evt_type evt_step(input spp_pkg::spp_evt_type evt,
                                                   input logic [1:0] phase,
                                                   input logic done);
    spp_pkg::spp_evt_type res;
    res = evt;
    unique case (evt)
      spp_pkg::EVT_IDLE: begin
        if (done) begin
          res = spp_pkg::EVT_WAIT_Q2;
        end
      end
      spp_pkg::EVT_WAIT_Q2: begin
        if (phase == `SPP_PHASE_Q2) begin
          res = spp_pkg::EVT_WAIT_Q4;
        end
      end
      spp_pkg::EVT_WAIT_Q4: begin
        if (phase == `SPP_PHASE_Q4) begin
          res = spp_pkg::EVT_IDLE;
        end
      end
      default: begin
        res = spp_pkg::EVT_IDLE;
      end
    endcase
    return res;
  endfunction

  // True in the cycle where a waiting event updates its flags.
  function automatic logic evt_fires(input spp_pkg::spp_evt_type evt,
                                     input logic [1:0] phase);
    return (evt == spp_pkg::EVT_WAIT_Q4) && (phase == `SPP_PHASE_Q4);
  endfunction

  // ----------------------------------------------------------------------
  // Strobe synchroniser
  // ----------------------------------------------------------------------

  spp_strobe_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .enable(st.enable),
    .pin_in(strobe_in),
    .data_in(data_in),
    .ev(ev)
  );

  assign wr_fire = evt_fires(st.wr_evt, st.phase);
  assign rd_fire = evt_fires(st.rd_evt, st.phase);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------

  // Computes all register, flag and pin updates for the coming edge.
  always_comb begin
    next_st = st;

    // Instruction cycle phases Q1 to Q4.
    next_st.phase = 2'(st.phase + 2'h1);

    if (st.phase == `SPP_PHASE_Q1) begin
      next_st.snap_data = data_in;
      next_st.snap_e = strobe_in;
    end

    if (ev.wr_act) begin
      next_st.in_latch = ev.data;
    end

    // Flag event sequencing after the strobes end.
    next_st.wr_evt = evt_step(st.wr_evt, st.phase, ev.wr_end);
    next_st.rd_evt = evt_step(st.rd_evt, st.phase, ev.rd_end);

    // Register writes; port latches are only queued here.
    if (wr_en) begin
      unique case (addr)
        `SPP_ADDR_DATA_PORT: begin
          next_st.pend_d_valid = 1'b1;
          next_st.pend_d = wr_data;
        end
        `SPP_ADDR_STROBE_PORT: begin
          next_st.pend_e_valid = 1'b1;
          next_st.pend_e = wr_data[2:0];
        end
        `SPP_ADDR_DATA_DIR: begin
          next_st.data_dir = wr_data;
        end
        `SPP_ADDR_STATUS: begin
          next_st.overflow = wr_data[`SPP_BIT_OVERFLOW];
          next_st.enable = wr_data[`SPP_BIT_ENABLE];
          next_st.e_dir = wr_data[2:0];
        end
        `SPP_ADDR_IRQ_FLAGS: begin
          next_st.irq_flag = wr_data[`SPP_BIT_IRQ];
        end
        `SPP_ADDR_IRQ_ENABLES: begin
          next_st.irq_enable = wr_data[`SPP_BIT_IRQ];
        end
        default: begin
        end
      endcase
    end

    if (st.phase == `SPP_PHASE_Q4) begin
      if (st.pend_d_valid) begin
        next_st.out_latch = st.pend_d;
        next_st.pend_d_valid = 1'b0;
        if (st.enable) begin
          next_st.output_full = 1'b1;
        end
      end
      if (st.pend_e_valid) begin
        next_st.e_latch = st.pend_e;
        next_st.pend_e_valid = 1'b0;
      end
    end

    if (rd_en && addr == `SPP_ADDR_DATA_PORT && st.enable) begin
      next_st.input_full = 1'b0;
    end

    if (ev.rd_start) begin
      next_st.output_full = 1'b0;
    end

    if (wr_fire) begin
      next_st.input_full = 1'b1;
      next_st.irq_flag = 1'b1;
      if (st.input_full) begin
        next_st.overflow = 1'b1;
      end
    end

    if (rd_fire) begin
      next_st.irq_flag = 1'b1;
    end

    if (!st.enable) begin
      next_st.input_full = 1'b0;
      next_st.output_full = 1'b0;
    end

    // Register read data for the following cycle only.
    next_st.rd_data = 8'h00;
    if (rd_en) begin
      unique case (addr)
        `SPP_ADDR_DATA_PORT: begin
          next_st.rd_data = st.enable ? st.in_latch : st.snap_data;
        end
        `SPP_ADDR_STROBE_PORT: begin
          next_st.rd_data = {5'h00, st.snap_e};
        end
        `SPP_ADDR_DATA_DIR: begin
          next_st.rd_data = st.data_dir;
        end
        `SPP_ADDR_STATUS: begin
          next_st.rd_data = {st.input_full, st.output_full, st.overflow, st.enable,
                             1'b0, st.e_dir};
        end
        `SPP_ADDR_IRQ_FLAGS: begin
          next_st.rd_data = {st.irq_flag, 7'h00};
        end
        `SPP_ADDR_IRQ_ENABLES: begin
          next_st.rd_data = {st.irq_enable, 7'h00};
        end
        default: begin
          next_st.rd_data = 8'h00;
        end
      endcase
    end

    // Data port pins.
    next_st.data_out = next_st.out_latch;
    if (next_st.enable) begin
      next_st.data_oe_b = ev.rd_act ? 8'h00 : 8'hFF;
    end else begin
      next_st.data_oe_b = next_st.data_dir;
    end

    next_st.e_out = next_st.e_latch;
    next_st.e_oe_b = next_st.e_dir;

    next_st.irq = next_st.irq_flag & next_st.irq_enable;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Loads the documented status value and quiet pins on reset.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '0;
      st.e_dir <= 3'(`SPP_RST_STATUS);
      st.e_oe_b <= 3'h7;
      st.data_dir <= `SPP_RST_DATA_DIR;
      st.data_oe_b <= `SPP_RST_DATA_DIR;
      st.out_latch <= `SPP_RST_LATCH;
      st.wr_evt <= spp_pkg::EVT_IDLE;
      st.rd_evt <= spp_pkg::EVT_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  // Every output is a field of the state register.
  assign rd_data = st.rd_data;
  assign data_out = st.data_out;
  assign data_oe_b = st.data_oe_b;
  assign strobe_out = st.e_out;
  assign strobe_oe_b = st.e_oe_b;
  assign irq = st.irq;

endmodule
`default_nettype wire

// ==== verif/spp_asserts.sv ====
// Pin-level checks for the slave port core.
`timescale 1ns/100ps
`default_nettype none
`include "spp_defines.svh"
module spp_asserts (
  input wire logic clk, // Clock.
  input wire logic rst_b, // Reset, low.
  input wire logic [7:0] addr, // Address.
  input wire logic [7:0] wr_data, // Write data.
  input wire logic wr_en, // Write strobe.
  input wire logic rd_en, // Read strobe.
  input wire logic [7:0] rd_data, // Read data.
  input wire logic [7:0] data_in, // Data pins.
  input wire logic [7:0] data_out, // Data drive.
  input wire logic [7:0] data_oe_b, // Data enable.
  input wire logic [2:0] strobe_in, // Strobe pins.
  input wire logic [2:0] strobe_out, // Strobe drive.
  input wire logic [2:0] strobe_oe_b, // Strobe enable.
  input wire logic irq // Interrupt.
);
  logic mode_h;
  logic irqen_h;
  logic [2:0] dir_h;
  logic [2:0] pin_h;
  logic [7:0] ddir_h;
  logic [7:0] out_h;

  // Shadows of the register fields that the pin checks depend on.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_h <= 1'b0;
      irqen_h <= 1'b0;
      dir_h <= 3'h7;
      pin_h <= 3'h0;
      ddir_h <= 8'hFF;
      out_h <= 8'h00;
    end else if (wr_en) begin
      case (addr)
        `SPP_ADDR_STATUS: begin
          mode_h <= wr_data[4];
          dir_h <= wr_data[2:0];
        end
        `SPP_ADDR_IRQ_ENABLES: irqen_h <= wr_data[7];
        `SPP_ADDR_DATA_DIR: ddir_h <= wr_data;
        `SPP_ADDR_DATA_PORT: out_h <= wr_data;
        `SPP_ADDR_STROBE_PORT: pin_h <= wr_data[2:0];
        default: ;
      endcase
    end
  end

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Strobe levels as the external processor presents them in slave mode.
  sequence read_s;
    mode_h && !strobe_in[2] && !strobe_in[0];
  endsequence
  sequence idle_s;
    mode_h && (strobe_in[2] || strobe_in[0]);
  endsequence
  sequence xfer_s;
    mode_h && irqen_h && !strobe_in[2] && strobe_in[1:0] != 2'b11;
  endsequence

  reset_out_a: assert property (disable iff (1'b0)
    !rst_b |=> data_oe_b == 8'hFF && strobe_oe_b == 3'h7 && !irq && data_out == 8'h00)
    else $error("outputs not at reset values");
  rd_idle_a: assert property (
    !rd_en |=> rd_data == 8'h00) else $error("read data not cleared");
  off_flags_a: assert property (
    !mode_h [*2] ##0 (rd_en && addr == `SPP_ADDR_STATUS) |=> rd_data[7:6] == 2'b00)
    else $error("full flags set outside slave mode");
  bus_drive_a: assert property (
    read_s [*6] |-> data_oe_b == 8'h00) else $error("data bus not driven in a read");
  bus_release_a: assert property (
    idle_s [*6] |-> data_oe_b == 8'hFF) else $error("data bus driven outside a read");
  latch_a: assert property (
    !wr_en [*6] |-> data_out == out_h && strobe_out == pin_h)
    else $error("port latch write not committed");
  dir_a: assert property (
    !wr_en [*3] |-> strobe_oe_b == dir_h && (mode_h || data_oe_b == ddir_h))
    else $error("pin enables differ from direction bits");
  irq_gate_a: assert property (
    !wr_en [*3] ##0 !irqen_h |-> !irq) else $error("interrupt raised while disabled");
  xfer_irq_a: assert property (
    xfer_s [*2] ##1 strobe_in[2] |-> ##[1:14] (irq || !irqen_h))
    else $error("no interrupt after a transfer");
endmodule
`default_nettype wire

// ==== verif/spp_ext_master.sv ====
// Behavioural external processor on the far side of the slave port.
`timescale 1ns/100ps
`default_nettype none
module spp_ext_master (
  input wire logic clk, // Clock that paces the strobes.
  input wire logic [7:0] bus, // Resolved data bus.
  output logic [2:0] strobe, // Select, write, read; active low.
  output logic [7:0] drive // Bus value where the core does not drive.
);
  // Idle: deselected; a released bus shows 5A, then the inverse of the last byte put.
  initial begin
    strobe = 3'h7;
    drive = 8'h5A;
  end

  task automatic put(input logic [7:0] d, input int hold);
    drive <= d;
    strobe <= 3'b001;
    repeat (hold) @(posedge clk);
    drive <= ~d;
    strobe <= 3'h7;
    repeat (12) @(posedge clk);
  endtask

  task automatic get(output logic [7:0] d, input int hold);
    strobe <= 3'b010;
    repeat (hold) @(posedge clk);
    d = bus;
    strobe <= 3'h7;
    repeat (12) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Bench for the slave port core with an external processor model.
`timescale 1ns/100ps
`default_nettype none
`include "spp_defines.svh"
module tb_top;
  logic clk;
  logic rst_b, wr_en, rd_en, irq;
  logic [7:0] addr, wr_data, rd_data, data_in, data_out, data_oe_b, m_drive, got;
  logic [2:0] strobe_in, strobe_out, strobe_oe_b, m_strobe;
  int errors = 0;
  int n_tests = 0;

  // Shared pins: the core wins where it drives, else the processor.
  assign data_in = (data_out & ~data_oe_b) | (m_drive & data_oe_b);
  assign strobe_in = (strobe_out & ~strobe_oe_b) | (m_strobe & strobe_oe_b);

  spp_core uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .data_in(data_in), .data_out(data_out),
    .data_oe_b(data_oe_b), .strobe_in(strobe_in), .strobe_out(strobe_out),
    .strobe_oe_b(strobe_oe_b), .irq(irq));
  spp_ext_master ext (.clk(clk), .bus(data_in), .strobe(m_strobe), .drive(m_drive));

  // Free-running 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk(rd_data, e);
    @(posedge clk);
  endtask

  task automatic end_of_test;
    $display("errors %0d, comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence of register and processor transfers.
  initial begin
    rst_b = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    tick(16);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(`SPP_ADDR_STATUS, 8'h07);
    rd(`SPP_ADDR_IRQ_ENABLES, 8'h00);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    // Plain port use: data pins driven from the latch, strobe pins left as inputs; reads give the pins.
    wr(`SPP_ADDR_DATA_DIR, 8'h00);
    wr(`SPP_ADDR_DATA_PORT, 8'hA5);
    wr(`SPP_ADDR_STROBE_PORT, 8'h05);
    tick(6);
    chk(data_out, 8'hA5);
    chk({5'h00, strobe_out}, 8'h05);
    rd(`SPP_ADDR_DATA_PORT, 8'hA5);
    rd(`SPP_ADDR_STROBE_PORT, 8'h07);
    // Bit-modify with the upper nibble as inputs picks up the pin levels.
    wr(`SPP_ADDR_DATA_DIR, 8'hF0);
    tick(6);
    rd(`SPP_ADDR_DATA_PORT, 8'h55);
    wr(`SPP_ADDR_DATA_PORT, 8'hD5);
    wr(`SPP_ADDR_DATA_DIR, 8'h00);
    tick(6);
    chk(data_out, 8'hD5);
    wr(`SPP_ADDR_IRQ_ENABLES, 8'h80);
    wr(`SPP_ADDR_STATUS, 8'h17);
    wr(`SPP_ADDR_DATA_PORT, 8'h3C);
    tick(6);
    chk(data_oe_b, 8'hFF);
    rd(`SPP_ADDR_STATUS, 8'h57);
    ext.get(got, 6);
    chk(got, 8'h3C);
    rd(`SPP_ADDR_STATUS, 8'h17);
    rd(`SPP_ADDR_IRQ_FLAGS, 8'h80);
    chk({7'h00, irq}, 8'h01);
    // Two writes without a firmware read, interrupt masked meanwhile.
    wr(`SPP_ADDR_IRQ_FLAGS, 8'h00);
    wr(`SPP_ADDR_IRQ_ENABLES, 8'h00);
    tick(2);
    chk({7'h00, irq}, 8'h00);
    ext.put(8'hC3, 2);
    rd(`SPP_ADDR_STATUS, 8'h97);
    ext.put(8'h69, 5);
    rd(`SPP_ADDR_STATUS, 8'hB7);
    rd(`SPP_ADDR_IRQ_FLAGS, 8'h80);
    chk({7'h00, irq}, 8'h00);
    wr(`SPP_ADDR_IRQ_ENABLES, 8'h80);
    tick(2);
    chk({7'h00, irq}, 8'h01);
    rd(`SPP_ADDR_DATA_PORT, 8'h69);
    rd(`SPP_ADDR_STATUS, 8'h37);
    // Leaving slave mode with a byte pending, then a refused transfer.
    wr(`SPP_ADDR_IRQ_FLAGS, 8'h00);
    ext.put(8'h11, 3);
    wr(`SPP_ADDR_STATUS, 8'h27);
    tick(4);
    rd(`SPP_ADDR_STATUS, 8'h27);
    wr(`SPP_ADDR_IRQ_FLAGS, 8'h00);
    ext.put(8'hEE, 3);
    rd(`SPP_ADDR_IRQ_FLAGS, 8'h00);
    rd(`SPP_ADDR_DATA_PORT, 8'h3C);
    wr(`SPP_ADDR_STATUS, 8'h07);
    rd(`SPP_ADDR_STATUS, 8'h07);
    wr(`SPP_ADDR_STATUS, 8'h1F);
    rd(`SPP_ADDR_STATUS, 8'h17);
    // Second reset in mid-run.
    rst_b <= 1'b0;
    tick(16);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(`SPP_ADDR_STATUS, 8'h07);
    chk(data_oe_b, 8'hFF);
    end_of_test();
  end
endmodule

bind spp_core spp_asserts chk_i (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .data_in(data_in), .data_out(data_out),
  .data_oe_b(data_oe_b), .strobe_in(strobe_in), .strobe_out(strobe_out),
  .strobe_oe_b(strobe_oe_b), .irq(irq));
`default_nettype wire
